/* File: hw/nvs_host.sv */
// Purpose: Host controller driving an asynchronous nonvolatile SRAM
// Assumes: One request at a time, pins sampled on clk
// Notes:   Busy line is open drain; device side may pull it low too
`timescale 1ns/1ps
module nvs_host #(
  parameter int STORE_TIMEOUT = nvs_pkg::STORE_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic                        req_store,
  input  wire logic [nvs_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [nvs_pkg::DATA_W-1:0]  req_wdata,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [nvs_pkg::DATA_W-1:0]       rsp_rdata,
  output logic                             store_timeout,
  output logic                             select_n,
  output logic                             write_n,
  output logic                             gate_n,
  output logic [nvs_pkg::ADDR_W-1:0]       address_pins,
  input  wire logic [nvs_pkg::DATA_W-1:0]  data_pins_in,
  output logic [nvs_pkg::DATA_W-1:0]       data_pins_out,
  output logic                             data_pins_oe_n,
  input  wire logic                        store_request_busy_n_in,
  output logic                             store_request_busy_n_out,
  output logic                             store_request_busy_n_oe_n
);
  import nvs_pkg::*;

  nvs_state_t                  state, next_state;
  logic [CNT_W-1:0]            cnt, next_cnt;
  logic                        next_req_ready, next_rsp_valid;
  logic [DATA_W-1:0]           next_rsp_rdata;
  logic                        next_store_timeout;
  logic                        next_select_n, next_write_n, next_gate_n;
  logic [ADDR_W-1:0]           next_address_pins;
  logic [DATA_W-1:0]           next_data_out;
  logic                        next_data_oe_n, next_hsb_oe_n;
  logic                        seen_busy, next_seen_busy;

  always_comb begin
    next_state         = state;
    next_cnt           = cnt + CNT_W'(1);
    next_req_ready     = 1'b0;
    next_rsp_valid     = 1'b0;
    next_rsp_rdata     = rsp_rdata;
    next_store_timeout = store_timeout;
    next_select_n      = select_n;
    next_write_n       = write_n;
    next_gate_n        = gate_n;
    next_address_pins  = address_pins;
    next_data_out      = data_pins_out;
    next_data_oe_n     = data_pins_oe_n;
    next_hsb_oe_n      = store_request_busy_n_oe_n;
    next_seen_busy     = seen_busy;
    case (state)
      NVS_IDLE: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_req_ready    = 1'b0;
          next_cnt          = '0;
          // Address moves only while select and strobe are high
          next_address_pins = req_addr; // see R24
          next_select_n     = 1'b0;
          if (req_store) begin
            next_select_n     = 1'b1;
            next_hsb_oe_n     = 1'b0; // see R17
            next_seen_busy    = 1'b0;
            next_store_timeout = 1'b0;
            next_state        = NVS_REQ;
          end else if (req_write) begin
            // Strobe and address together: address setup of zero holds
            next_write_n   = 1'b0; // see R13
            next_data_out  = req_wdata; // see R12
            next_data_oe_n = 1'b0;
            next_state     = NVS_WRITE; // see R14
          end else begin
            next_gate_n = 1'b0; // see R4
            next_state  = NVS_READ;
          end
        end
      end
      NVS_READ: begin
        if (cnt == CNT_W'(ACCESS_CYC - 1)) begin
          // Sampled a full access time after select, gate and address
          next_rsp_rdata = data_pins_in; // see R6
          next_rsp_valid = 1'b1;
          next_select_n  = 1'b1;
          next_gate_n    = 1'b1;
          next_cnt       = '0;
          next_state     = NVS_GAP;
        end
      end
      NVS_WRITE: begin
        if (cnt == CNT_W'(WRITE_CYC + SETUP_CYC - 1)) begin
          next_write_n   = 1'b1; // see R11
          next_select_n  = 1'b1;
          next_rsp_valid = 1'b1;
          next_cnt       = '0;
          next_state     = NVS_GAP;
        end
      end
      NVS_GAP: begin
        // Data released one cycle after strobe end, hold time is zero
        next_data_oe_n = 1'b1;
        if (cnt == CNT_W'(GAP_CYC - 1)) begin
          next_state = NVS_IDLE;
        end
      end
      NVS_REQ: begin
        // Line is low from our own pull here, so busy is not sampled yet
        if (cnt == CNT_W'(REQ_CYC - 1)) begin
          next_hsb_oe_n = 1'b1;
          next_cnt      = '0;
          next_state    = NVS_STORE;
        end
      end
      NVS_STORE: begin
        // Skipped store never pulls busy, so a missing busy is not fatal
        if (!store_request_busy_n_in) next_seen_busy = 1'b1;
        if ((cnt >= CNT_W'(BUSY_WAIT) || seen_busy) &&
            store_request_busy_n_in) begin
          next_cnt   = '0;
          next_state = NVS_RECOVER;
        end else if (cnt == CNT_W'(STORE_TIMEOUT)) begin
          next_store_timeout = 1'b1; // see R19
          next_cnt           = '0;
          next_state         = NVS_RECOVER;
        end
      end
      NVS_RECOVER: begin
        if (cnt == CNT_W'(RECOVER_CYC - 1)) begin
          next_rsp_valid = 1'b1; // see R22
          next_state     = NVS_IDLE;
        end
      end
      default: begin
        next_state = NVS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state                     <= NVS_IDLE;
      cnt                       <= '0;
      req_ready                 <= 1'b0;
      rsp_valid                 <= 1'b0;
      rsp_rdata                 <= '0;
      store_timeout             <= 1'b0;
      select_n                  <= 1'b1;
      write_n                   <= 1'b1;
      gate_n                    <= 1'b1;
      address_pins              <= '0;
      data_pins_out             <= '0;
      data_pins_oe_n            <= 1'b1;
      store_request_busy_n_oe_n <= 1'b1;
      store_request_busy_n_out  <= 1'b0;
      seen_busy                 <= 1'b0;
    end else begin
      state                     <= next_state;
      cnt                       <= next_cnt;
      req_ready                 <= next_req_ready;
      rsp_valid                 <= next_rsp_valid;
      rsp_rdata                 <= next_rsp_rdata;
      store_timeout             <= next_store_timeout;
      select_n                  <= next_select_n;
      write_n                   <= next_write_n;
      gate_n                    <= next_gate_n;
      address_pins              <= next_address_pins;
      data_pins_out             <= next_data_out;
      data_pins_oe_n            <= next_data_oe_n;
      store_request_busy_n_oe_n <= next_hsb_oe_n;
      store_request_busy_n_out  <= 1'b0;
      seen_busy                 <= next_seen_busy;
    end
  end

  property p_read_strobes_high;
    @(posedge clk) disable iff (!reset_n)
      (!gate_n && !select_n) |-> (write_n && store_request_busy_n_oe_n);
  endproperty
  a_read_strobes_high: assert property (p_read_strobes_high) // see R4
    else $error("strobe or store line low during read");

  property p_write_pulse;
    @(posedge clk) disable iff (!reset_n)
      $fell(write_n) |-> !write_n [*2] ##0 !select_n;
  endproperty
  a_write_pulse: assert property (p_write_pulse) // see R11
    else $error("write pulse too short");

  property p_data_setup;
    @(posedge clk) disable iff (!reset_n)
      $rose(write_n) |-> $past(!data_pins_oe_n, 1) &&
                         $stable(data_pins_out);
  endproperty
  a_data_setup: assert property (p_data_setup) // see R12
    else $error("write data not stable at write end");

  property p_addr_stable;
    @(posedge clk) disable iff (!reset_n)
      !$stable(address_pins) |-> $past(select_n) && $past(write_n);
  endproperty
  a_addr_stable: assert property (p_addr_stable) // see R13
    else $error("address changed during access");

  property p_store_high_in_write;
    @(posedge clk) disable iff (!reset_n)
      !write_n |-> store_request_busy_n_oe_n;
  endproperty
  a_store_high_in_write: assert property (p_store_high_in_write) // see R14
    else $error("store line low during write");

  property p_req_pulse;
    @(posedge clk) disable iff (!reset_n)
      $fell(store_request_busy_n_oe_n) |-> !store_request_busy_n_oe_n [*1]
        ##1 $rose(store_request_busy_n_oe_n);
  endproperty
  a_req_pulse: assert property (p_req_pulse) // see R17
    else $error("store request pulse wrong length");

  property p_read_spacing;
    @(posedge clk) disable iff (!reset_n)
      $rose(select_n) |-> select_n [*2];
  endproperty
  a_read_spacing: assert property (p_read_spacing) // see R6
    else $error("cycles too close together");

  property p_no_contention;
    @(posedge clk) disable iff (!reset_n)
      !gate_n |-> data_pins_oe_n;
  endproperty
  a_no_contention: assert property (p_no_contention) // see R24
    else $error("host drives data while gate low");

  c_read:  cover property (@(posedge clk) $fell(gate_n));
  c_write: cover property (@(posedge clk) $fell(write_n));
  c_store: cover property (@(posedge clk) state == NVS_RECOVER);
  c_tmo:   cover property (@(posedge clk) $rose(store_timeout));
endmodule

/* File: hw/nvs_pkg.sv */
// Purpose: Constants for the host-side nonvolatile SRAM access controller
// Assumes: 20 MHz clock, fastest speed grade of the memory
// Notes:   Overview list below; times in ns except STORE_MS in ms, cycle counts derived
//
// Overview of operation
// R1: Device reads addressed byte when select and gate low, strobe and busy high.
// R2: Device writes data pins when select and strobe low and busy high.
// R3: Select high deselects device; data floats within 13 ns.
// R4: Host keeps write strobe and store line high through every read.
// R5: Read data valid no later than 35 ns after select falls.
// R6: Host spaces reads 35 ns apart; data valid 35 ns after address.
// R7: Read data valid within 15 ns of output gate falling.
// R8: Device floats data within 13 ns after output gate rises.
// R9: Device drives data no earlier than 5 ns after select falls.
// R10: Device reaches standby within 35 ns of select rising.
// R11: Host holds strobe and select low at least 25 ns before write end.
// R12: Host sets write data 12 ns before write end; may drop at end.
// R13: Host sets address 25 ns before write end, from start, held to end.
// R14: Host keeps store line high during every write.
// R15: Strobe low at select fall keeps device outputs floating.
// R16: Device floats data within 13 ns of strobe falling.
// R17: Host pulls store line low at least 15 ns to request a store.
// R18: Store happens only if a write occurred since last nonvolatile cycle.
// R19: Device allows 1 us for cycle finish, store done within 10 ms.
// R20: Device pulls busy low within 300 ns after store request.
// R21: After store, device refuses accesses while store line stays low.
// R22: Device lifts inhibit within 700 ns after store line returns high.
// R23: Output timing holds only with select and gate low, strobe high.
// R24: Host keeps select or strobe high while address lines change.
package nvs_pkg;
  localparam int          CLK_NS          = 50;
  localparam int          ADDR_W          = 15;
  localparam int          DATA_W          = 8;
  localparam int          READ_CYCLE_NS   = 35;
  localparam int          ACCESS_NS       = 35;
  localparam int          GATE_DATA_NS    = 15;
  localparam int          WRITE_PULSE_NS  = 25;
  localparam int          DATA_SETUP_NS   = 12;
  localparam int          ADDR_SETUP_NS   = 25;
  localparam int          FLOAT_NS        = 13;
  localparam int          REQ_PULSE_NS    = 15;
  localparam int          REQ_BUSY_NS     = 300;
  localparam int          STORE_MS        = 10;
  localparam int          RECOVER_NS      = 700;
  // Least times round up, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int ACCESS_CYC  = cyc_min(ACCESS_NS > GATE_DATA_NS ?
                                       ACCESS_NS : GATE_DATA_NS) + 1;
  localparam int WRITE_CYC   = cyc_min(WRITE_PULSE_NS > ADDR_SETUP_NS ?
                                       WRITE_PULSE_NS : ADDR_SETUP_NS);
  localparam int SETUP_CYC   = cyc_min(DATA_SETUP_NS);
  localparam int GAP_CYC     = cyc_min(FLOAT_NS);
  localparam int REQ_CYC     = cyc_min(REQ_PULSE_NS);
  localparam int BUSY_WAIT   = cyc_min(REQ_BUSY_NS) + 1;
  localparam int STORE_CYC   = (STORE_MS * 1000000) / CLK_NS;
  localparam int RECOVER_CYC = cyc_min(RECOVER_NS) + 1;
  localparam int CNT_W       = 20;
  typedef enum logic [6:0] {
    NVS_IDLE    = 7'h01,
    NVS_READ    = 7'h02,
    NVS_WRITE   = 7'h04,
    NVS_GAP     = 7'h08,
    NVS_REQ     = 7'h10,
    NVS_STORE   = 7'h20,
    NVS_RECOVER = 7'h40
  } nvs_state_t;
endpackage

/* File: verif/nv_sram_access_and_hw_store_tb.sv */
// Purpose: Self-checking bench for the nonvolatile memory host
// Assumes: Store timeout shortened to 50 cycles
// Notes:   Pin monitor runs beside the scenario tasks
`timescale 1ns/1ps
module nv_sram_access_and_hw_store_tb;
  import nvs_pkg::*;
  logic              clk = 1'b0, reset_n = 1'b0, slow = 1'b0;
  logic              req_valid = 1'b0, req_write = 1'b0, req_store = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0, address_pins, wa = '0;
  logic [DATA_W-1:0] req_wdata = '0, got, rsp_rdata, dq_out, dev_dq, data_line;
  logic              req_ready, rsp_valid, store_timeout, select_n, write_n;
  logic              gate_n, dq_oe_n, hb_out, hb_oe_n, dev_busy_n, busy_line;
  logic              wlow = 1'b0;
  int                bad_count = 0, comparisons = 0, store_count, n, i;
  assign data_line = dq_oe_n ? dev_dq : dq_out;
  assign busy_line = (hb_oe_n | hb_out) & dev_busy_n;
  nvs_host #(.STORE_TIMEOUT(50)) u_dut (.clk(clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_write(req_write), .req_store(req_store),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .store_timeout(store_timeout), .select_n(select_n), .write_n(write_n),
    .gate_n(gate_n), .address_pins(address_pins), .data_pins_in(data_line),
    .data_pins_out(dq_out), .data_pins_oe_n(dq_oe_n),
    .store_request_busy_n_in(busy_line), .store_request_busy_n_out(hb_out),
    .store_request_busy_n_oe_n(hb_oe_n));
  nvs_mem_model u_mem (.select_n(select_n), .write_n(write_n),
    .gate_n(gate_n), .address_pins(address_pins), .data_line(data_line),
    .busy_line(busy_line), .slow(slow), .dev_dq(dev_dq),
    .dev_busy_n(dev_busy_n), .store_count(store_count));
  initial forever #25 clk = ~clk;
  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Every wait is bounded; running out counts as a mismatch
  task automatic wait_cyc;
    @(posedge clk);
    #1;
    n++;
    if (n > 400) begin
      check(0, 1);
      close_out();
    end
  endtask
  task automatic op(input logic wr, input logic st,
                    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    n = 0;
    while (req_ready !== 1'b1) wait_cyc();
    req_valid = 1'b1;
    req_write = wr;
    req_store = st;
    req_addr = a;
    req_wdata = d;
    @(posedge clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && !(st && store_timeout === 1'b1)) wait_cyc();
    got = rsp_rdata;
  endtask
  // Host pin discipline, sampled on every rising edge
  always @(posedge clk) begin
    if (reset_n) begin
      if (!select_n && !gate_n) check(write_n, 1);
      if (!select_n && !gate_n) check(hb_oe_n, 1);
      if (!select_n && !write_n) check(hb_oe_n, 1);
      if (!select_n && !write_n) check(dq_oe_n, 0);
      if (wlow && !select_n && !write_n) check(address_pins, wa);
    end
    wlow = !select_n && !write_n;
    wa = address_pins;
  end
  task automatic t_clean_store;
    op(0, 1, '0, '0);
    check(store_count, 0);
    check(store_timeout, 0);
    $display("test clean store done");
  endtask
  task automatic t_write_read;
    logic [ADDR_W-1:0] a [3] = '{15'h0000, 15'h7fff, 15'h1234};
    logic [DATA_W-1:0] d [3] = '{8'ha5, 8'h5a, 8'h3c};
    for (i = 0; i < 3; i++) op(1, 0, a[i], d[i]);
    for (i = 2; i >= 0; i--) begin
      op(0, 0, a[i], '0);
      check(got, d[i]);
    end
    $display("test write read done");
  endtask
  task automatic t_dirty_store;
    op(1, 0, 15'h0100, 8'hc3);
    op(0, 1, '0, '0);
    check(store_count, 1);
    check(store_timeout, 0);
    op(0, 0, 15'h0100, '0);
    check(got, 8'hc3);
    $display("test dirty store done");
  endtask
  task automatic t_slow_store;
    slow = 1'b1;
    op(1, 0, 15'h0200, 8'h96);
    op(0, 1, '0, '0);
    check(store_timeout, 1);
    n = 0;
    while (dev_busy_n !== 1'b1) wait_cyc();
    slow = 1'b0;
    repeat (15) @(posedge clk);
    #1;
    op(0, 1, '0, '0);
    check(store_timeout, 0);
    check(store_count, 2);
    op(0, 0, 15'h0200, '0);
    check(got, 8'h96);
    $display("test slow store done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_clean_store();
    t_write_read();
    t_dirty_store();
    t_slow_store();
    close_out();
  end
endmodule

/* File: verif/nvs_mem_model.sv */
// Purpose: Behavioural nonvolatile memory facing the host controller
// Assumes: Busy line is resolved outside with a pull-up
// Notes:   Input slow stretches a store past the 50-cycle store timeout set in the bench
`timescale 1ns/1ps
module nvs_mem_model (
  input  wire logic                       select_n,
  input  wire logic                       write_n,
  input  wire logic                       gate_n,
  input  wire logic [nvs_pkg::ADDR_W-1:0] address_pins,
  input  wire logic [nvs_pkg::DATA_W-1:0] data_line,
  input  wire logic                       busy_line,
  input  wire logic                       slow,
  output logic [nvs_pkg::DATA_W-1:0]      dev_dq,
  output logic                            dev_busy_n,
  output int                              store_count
);
  import nvs_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last    = 8'h00;
  logic              dirty   = 1'b0;
  logic              inhibit = 1'b0;
  logic              drv     = 1'b0;
  wire               drive;
  // Released bus shows the inverse of the last byte, never a stale copy
  assign drive = !select_n && !gate_n && write_n && busy_line &&
                 !inhibit;
  assign dev_dq = drv ? mem[address_pins] : ~last;
  initial begin
    dev_busy_n = 1'b1;
    store_count = 0;
  end
  always @(drive) begin
    if (drive) drv <= #15 1'b1;
    else drv = 1'b0;
  end
  always @(drv or address_pins) begin
    if (drv) last = mem[address_pins];
  end
  always @(*) begin
    if (!select_n && !write_n && busy_line && !inhibit) begin
      mem[address_pins] = data_line;
      dirty = 1'b1;
    end
  end
  always @(negedge busy_line) begin
    inhibit = 1'b1;
    if (dirty) begin
      #20 dev_busy_n = 1'b0;
      #(slow ? 5000 : 1000);
      dirty = 1'b0;
      store_count++;
      dev_busy_n = 1'b1;
    end
  end
  always @(posedge busy_line) inhibit <= #200 1'b0;
endmodule
